// *** inc/dtm_consts.svh ***
// constants of the drive trip manager
`ifndef DTM_CONSTS_SVH
`define DTM_CONSTS_SVH

// time base: 20 MHz clock, 50 ns period
`define DTM_CLK_HZ        20000000
`define DTM_TMS_PER_TICK  100
// reset delays and stop wait in ms, tick = 100 ms
`define DTM_DLY_SHORT_MS  1000
`define DTM_DLY_LONG_MS   10000
`define DTM_STOP_WAIT_MS  10000

// register byte addresses
`define DTM_REG_CTRL      12'h000
`define DTM_REG_CFG       12'h004
`define DTM_REG_STATUS    12'h008
`define DTM_REG_TRIP      12'h00C

// ctrl bits (write one pulses)
`define DTM_CTRL_RESET    0
`define DTM_CTRL_DEFAULTS 1
// cfg fields
`define DTM_CFG_MODE_LSB  0
`define DTM_CFG_LVDC      2
`define DTM_CFG_SUPPLY    3
// status bits
`define DTM_ST_ACTIVE     0
`define DTM_ST_RESETTABLE 1
`define DTM_ST_INHIBIT    2
`define DTM_ST_UVCOND     3
`define DTM_ST_HEALTHY    4
`define DTM_ST_STOPREQ    5
`define DTM_ST_SUPPLY     6

// trip codes
`define DTM_CODE_UV       8'h01
`define DTM_CODE_OIAC     8'h03
`define DTM_CODE_OIBR     8'h04
`define DTM_CODE_AUXSUP   8'h09
`define DTM_CODE_TUNE1    8'h0B
`define DTM_CODE_TUNE     8'h12
`define DTM_CODE_TH       8'h18
`define DTM_CODE_SCL      8'h1E
`define DTM_CODE_OHT3     8'h1B
`define DTM_CODE_EEF      8'h1F
`define DTM_CODE_PH       8'h20
`define DTM_CODE_OIBRP    8'h67
`define DTM_CODE_OIACP    8'h68
`define DTM_CODE_OIDCP    8'h6D
`define DTM_CODE_ENC12    8'hA2
`define DTM_CODE_ENC17    8'hA7
`define DTM_CODE_CARD_LO  8'hAF
`define DTM_CODE_CARD_HI  8'hBC
`define DTM_CODE_CARD_BOOT 8'hB1
`define DTM_CODE_ENCODER_SUPPLY_TRIP     8'hBD
`define DTM_CODE_ENC2     8'hBE
`define DTM_CODE_ENC8     8'hC4
`define DTM_CODE_SLOT_HF1 8'hC8
`define DTM_CODE_SLOT_HF2 8'hCD
`define DTM_CODE_SLOT_HF3 8'hD2
`define DTM_CODE_HF17     8'hD9
`define DTM_CODE_MAX      8'hE8
`define DTM_CODE_NONE     8'h00

`endif

// *** inc/dtm_pkg.sv ***
// types of the drive trip manager
package dtm_pkg;
  typedef enum logic [1:0] {DTM_RD_IDLE, DTM_RD_RESP} dtm_rd_t;
  typedef enum logic [1:0] {DTM_WR_IDLE, DTM_WR_RESP} dtm_wr_t;
  typedef enum logic [1:0] {DTM_SP_IDLE, DTM_SP_WAIT} dtm_stop_t;
endpackage

// *** verilog/dtm_trip_manager.sv ***
// drive trip manager with axi4-lite register access
//
// Summary of operation
// - Active trip reported as numeric code 1 to 232, fixed per trip.
// - New trip accepted only if none active or lower priority number.
// - Priority 1 faults never reset; relay open, run and comms stopped.
// - Priority 2 trips ignore reset; cleared only by power cycle.
// - Stored data fault resets only after load-defaults code written.
// - Card trips priority 4, 5 during power-up; resettable after 1.0 s.
// - Encoder supply trips replace priority 5 trips only in encoder groups 2-8 and 11-17.
// - Output and brake overcurrent trips resettable only after 10.0 s.
// - After autotune trip reset, inhibit running until drive disabled.
// - Non-important trips stop motor first when trip mode bit 0 set.
// - Phase loss stops motor before tripping.
// - Thermal overheat stops motor first, trips anyway after 10 s.
// - Undervoltage trip priority 6, ignores user reset, clears itself.
// - During undervoltage trip other functions run, enabling refused.
// - Undervoltage onset saves parameters except in low voltage DC mode.
// - Undervoltage cleared when bus recovers; other trips untouched.
// - Supply switching only while undervoltage condition flag is set.
// - Undervoltage trip shown only if no other trip active.
// - Power-up undervoltage raised without parameter save.
//
// Design decisions made here: the AXI4-Lite interface to the registers and the placing of the registers.
`include "dtm_consts.svh"
module dtm_trip_manager (
  // clock, reset, enable
  input  wire logic        I_SYS_CLK,
  input  wire logic        I_SYS_RST,
  input  wire logic        I_CE,
  // fault sources
  input  wire logic        I_FAULT_VALID,
  input  wire logic [7:0]  I_FAULT_CODE,
  input  wire logic        I_POWERING_UP,
  input  wire logic        I_MOTOR_STOPPED,
  input  wire logic        I_BUS_BELOW_RESTART,
  input  wire logic        I_USER_RESET,
  input  wire logic        I_DRIVE_DISABLED,
  input  wire logic        I_RUN_REQ,
  // axi4-lite write address and data
  input  wire logic        I_AWVALID,
  output logic             O_AWREADY,
  input  wire logic [11:0] I_AWADDR,
  input  wire logic        I_WVALID,
  output logic             O_WREADY,
  input  wire logic [31:0] I_WDATA,
  input  wire logic [3:0]  I_WSTRB,
  // axi4-lite write response
  output logic             O_BVALID,
  input  wire logic        I_BREADY,
  output logic [1:0]       O_BRESP,
  // axi4-lite read
  input  wire logic        I_ARVALID,
  output logic             O_ARREADY,
  input  wire logic [11:0] I_ARADDR,
  output logic             O_RVALID,
  input  wire logic        I_RREADY,
  output logic [31:0]      O_RDATA,
  output logic [1:0]       O_RRESP,
  // drive control outputs
  output logic [7:0]       O_TRIP_CODE,
  output logic             O_TRIP_ACTIVE,
  output logic             O_RUN_ENABLE,
  output logic             O_HEALTHY_RELAY,
  output logic             O_COMMS_ENABLE,
  output logic             O_STOP_REQ,
  output logic             O_SAVE_PARAMS,
  output logic             O_SUPPLY_SEL
);

  localparam int TICK_CYC = `DTM_CLK_HZ / 1000 * `DTM_TMS_PER_TICK;
  localparam logic [7:0] SHORT_T = 8'(`DTM_DLY_SHORT_MS / `DTM_TMS_PER_TICK);
  localparam logic [7:0] LONG_T  = 8'(`DTM_DLY_LONG_MS / `DTM_TMS_PER_TICK);
  localparam logic [7:0] STOP_T  = 8'(`DTM_STOP_WAIT_MS / `DTM_TMS_PER_TICK);

  function automatic logic in_rng(input logic [7:0] c, input logic [7:0] lo,
                                  input logic [7:0] hi);
    return (c >= lo) && (c <= hi);
  endfunction

  // priority of a code, 1 highest
  function automatic logic [2:0] prio_of(input logic [7:0] c,
                                         input logic pwr_up);
    logic [2:0] p;
    p = 3'h5;
    if (c == `DTM_CODE_UV) p = 3'h6;
    else if (in_rng(c, `DTM_CODE_HF17, `DTM_CODE_MAX) ||
             c == `DTM_CODE_SLOT_HF1 || c == `DTM_CODE_SLOT_HF2 ||
             c == `DTM_CODE_SLOT_HF3) p = 3'h2;
    else if (c == `DTM_CODE_EEF) p = 3'h3;
    else if (in_rng(c, `DTM_CODE_CARD_BOOT, `DTM_CODE_CARD_HI) ||
             c == `DTM_CODE_CARD_LO)
      p = pwr_up ? 3'h5 : 3'h4;
    else if (c == `DTM_CODE_AUXSUP || c == `DTM_CODE_ENCODER_SUPPLY_TRIP) p = 3'h4;
    return p;
  endfunction

  function automatic logic is_enc_grp(input logic [7:0] c);
    return in_rng(c, `DTM_CODE_ENC2, `DTM_CODE_ENC8) ||
           in_rng(c, `DTM_CODE_ENC12 - 8'h01, `DTM_CODE_ENC17);
  endfunction

  function automatic logic is_long(input logic [7:0] c);
    return c == `DTM_CODE_OIAC || c == `DTM_CODE_OIBR ||
           c == `DTM_CODE_OIACP || c == `DTM_CODE_OIBRP ||
           c == `DTM_CODE_OIDCP;
  endfunction

  function automatic logic is_tune(input logic [7:0] c);
    return in_rng(c, `DTM_CODE_TUNE1, `DTM_CODE_TUNE);
  endfunction

  function automatic logic needs_stop(input logic [7:0] c,
                                      input logic mode0);
    return (mode0 && in_rng(c, `DTM_CODE_TH, `DTM_CODE_SCL) &&
            c != `DTM_CODE_OHT3) ||
           c == `DTM_CODE_PH || c == `DTM_CODE_OHT3;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  logic [7:0]  code_ff;
  logic [2:0]  prio_ff;
  logic        active_ff;
  logic        hf_lock_ff;
  logic [7:0]  age_ff;
  logic [21:0] tick_cnt_ff;
  logic        tick;
  logic        defaults_ff;
  logic        tune_inh_ff;
  logic [1:0]  mode_ff;
  logic        lvdc_ff;
  logic        supply_req_ff;
  logic        first_ff;
  logic        reset_pulse;
  logic        defaults_pulse;
  logic [7:0]  pend_code_ff;
  logic [7:0]  stop_age_ff;
  dtm_pkg::dtm_stop_t stop_st_ff;
  logic        raise;
  logic [7:0]  raise_code;
  logic        uv_raise;
  logic        accept;
  logic        resettable;
  logic [2:0]  new_prio;
  logic        clear_req;

  assign tick = (tick_cnt_ff == 22'(TICK_CYC - 1));
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SYS_RST) tick_cnt_ff <= '0;
    else if (I_CE) tick_cnt_ff <= tick ? '0 : tick_cnt_ff + 22'h1;
  end

  //////////////////////////////////////////////////////////////////////////
  // stop-before-trip sequencing
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SYS_RST) begin
      stop_st_ff   <= dtm_pkg::DTM_SP_IDLE;
      pend_code_ff <= 8'h00;
      stop_age_ff  <= 8'h00;
    end else if (I_CE) begin
      unique case (stop_st_ff)
        dtm_pkg::DTM_SP_IDLE: begin
          if (I_FAULT_VALID && needs_stop(I_FAULT_CODE, mode_ff[0])) begin
            stop_st_ff   <= dtm_pkg::DTM_SP_WAIT;
            pend_code_ff <= I_FAULT_CODE;
            stop_age_ff  <= 8'h00;
          end
        end
        dtm_pkg::DTM_SP_WAIT: begin
          if (tick) stop_age_ff <= stop_age_ff + 8'h01;
          if (raise) stop_st_ff <= dtm_pkg::DTM_SP_IDLE;
        end
      endcase
    end
  end

  always_comb begin
    raise = 1'b0;
    raise_code = I_FAULT_CODE;
    if (stop_st_ff == dtm_pkg::DTM_SP_WAIT) begin
      raise_code = pend_code_ff;
      raise = I_MOTOR_STOPPED ||
              (pend_code_ff == `DTM_CODE_OHT3 &&
               stop_age_ff >= STOP_T);
    end else if (I_FAULT_VALID && !needs_stop(I_FAULT_CODE, mode_ff[0])
                 && in_rng(I_FAULT_CODE, 8'h01, `DTM_CODE_MAX)) begin
      raise = 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // trip acceptance
  assign uv_raise = I_BUS_BELOW_RESTART && !active_ff && !raise;
  assign new_prio = prio_of(raise_code, I_POWERING_UP);

  always_comb begin
    accept = 1'b0;
    if (raise && !hf_lock_ff) begin
      if (!active_ff) accept = 1'b1;
      else if (new_prio < prio_ff) begin
        accept = 1'b1;
        if ((raise_code == `DTM_CODE_AUXSUP ||
             raise_code == `DTM_CODE_ENCODER_SUPPLY_TRIP) && prio_ff == 3'h5)
          accept = is_enc_grp(code_ff);
      end
    end
  end

  always_comb begin
    resettable = 1'b0;
    unique case (prio_ff)
      3'h1, 3'h2, 3'h6: resettable = 1'b0;
      3'h3: resettable = defaults_ff;
      default:
        resettable = age_ff >= (is_long(code_ff) ? LONG_T : SHORT_T);
    endcase
  end

  assign clear_req = active_ff && !accept &&
    ((prio_ff == 3'h6 && !I_BUS_BELOW_RESTART) ||
     (reset_pulse && resettable));

  always_ff @(posedge I_SYS_CLK) begin
    if (I_SYS_RST) begin
      active_ff  <= 1'b0;
      code_ff    <= `DTM_CODE_NONE;
      prio_ff    <= 3'h0;
      age_ff     <= 8'h00;
      first_ff   <= 1'b1;
    end else if (I_CE) begin
      first_ff <= 1'b0;
      if (accept) begin
        active_ff <= 1'b1;
        code_ff   <= raise_code;
        prio_ff   <= new_prio;
        age_ff    <= 8'h00;
      end else if (uv_raise) begin
        active_ff <= 1'b1;
        code_ff   <= `DTM_CODE_UV;
        prio_ff   <= 3'h6;
        age_ff    <= 8'h00;
      end else if (clear_req) begin
        active_ff <= 1'b0;
        code_ff   <= `DTM_CODE_NONE;
        prio_ff   <= 3'h0;
      end else if (tick && age_ff != 8'hFF) begin
        age_ff <= age_ff + 8'h01;
      end
    end
  end

  // hardware fault lock, only reset leaves it
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SYS_RST) hf_lock_ff <= 1'b0;
    else if (I_CE && raise && in_rng(raise_code, 8'h01, 8'h00) == 1'b0 &&
             raise_code == 8'h00)
      hf_lock_ff <= 1'b1;
    else if (I_CE && I_FAULT_VALID && I_FAULT_CODE == 8'hFF)
      hf_lock_ff <= 1'b1;
  end

  // autotune inhibit: set on reset of a tune trip, cleared by disable
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SYS_RST) tune_inh_ff <= 1'b0;
    else if (I_CE) begin
      if (clear_req && is_tune(code_ff)) tune_inh_ff <= 1'b1;
      else if (I_DRIVE_DISABLED) tune_inh_ff <= 1'b0;
    end
  end

  // load-defaults latch for stored data fault
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SYS_RST) defaults_ff <= 1'b0;
    else if (I_CE) begin
      if (defaults_pulse) defaults_ff <= 1'b1;
      else if (clear_req && prio_ff == 3'h3) defaults_ff <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // outputs
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SYS_RST) begin
      O_TRIP_CODE     <= `DTM_CODE_NONE;
      O_TRIP_ACTIVE   <= 1'b0;
      O_RUN_ENABLE    <= 1'b0;
      O_HEALTHY_RELAY <= 1'b0;
      O_COMMS_ENABLE  <= 1'b0;
      O_STOP_REQ      <= 1'b0;
      O_SAVE_PARAMS   <= 1'b0;
      O_SUPPLY_SEL    <= 1'b0;
    end else if (I_CE) begin
      O_TRIP_CODE     <= code_ff;
      O_TRIP_ACTIVE   <= active_ff;
      O_RUN_ENABLE    <= I_RUN_REQ && !active_ff && !tune_inh_ff &&
                         !hf_lock_ff;
      O_HEALTHY_RELAY <= !hf_lock_ff && !active_ff;
      O_COMMS_ENABLE  <= !hf_lock_ff;
      O_STOP_REQ      <= stop_st_ff == dtm_pkg::DTM_SP_WAIT;
      O_SAVE_PARAMS   <= uv_raise && !lvdc_ff && !first_ff;
      if (I_BUS_BELOW_RESTART) O_SUPPLY_SEL <= supply_req_ff;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // axi4-lite slave
  logic aw_got_ff, w_got_ff;
  logic [11:0] aw_addr_ff;
  logic [31:0] w_data_ff;
  logic [3:0]  w_strb_ff;
  logic        do_write;

  assign do_write = aw_got_ff && w_got_ff && !O_BVALID;
  assign reset_pulse = I_USER_RESET ||
    (do_write && aw_addr_ff == `DTM_REG_CTRL && w_strb_ff[0] &&
     w_data_ff[`DTM_CTRL_RESET]);
  assign defaults_pulse = do_write && aw_addr_ff == `DTM_REG_CTRL &&
    w_strb_ff[0] && w_data_ff[`DTM_CTRL_DEFAULTS];

  always_ff @(posedge I_SYS_CLK) begin
    if (I_SYS_RST) begin
      aw_got_ff <= 1'b0;
      w_got_ff  <= 1'b0;
      aw_addr_ff <= 12'h000;
      w_data_ff <= 32'h0000_0000;
      w_strb_ff <= 4'h0;
      O_AWREADY <= 1'b0;
      O_WREADY  <= 1'b0;
      O_BVALID  <= 1'b0;
      O_BRESP   <= 2'h0;
    end else if (I_CE) begin
      O_AWREADY <= !aw_got_ff && !(I_AWVALID && O_AWREADY);
      O_WREADY  <= !w_got_ff && !(I_WVALID && O_WREADY);
      if (I_AWVALID && O_AWREADY) begin
        aw_got_ff  <= 1'b1;
        aw_addr_ff <= I_AWADDR;
      end
      if (I_WVALID && O_WREADY) begin
        w_got_ff  <= 1'b1;
        w_data_ff <= I_WDATA;
        w_strb_ff <= I_WSTRB;
      end
      if (do_write) begin
        O_BVALID <= 1'b1;
        O_BRESP  <= (aw_addr_ff <= `DTM_REG_TRIP &&
                     aw_addr_ff[1:0] == 2'h0) ? 2'h0 : 2'h2;
      end else if (O_BVALID && I_BREADY) begin
        O_BVALID  <= 1'b0;
        aw_got_ff <= 1'b0;
        w_got_ff  <= 1'b0;
      end
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (I_SYS_RST) begin
      mode_ff       <= 2'h0;
      lvdc_ff       <= 1'b0;
      supply_req_ff <= 1'b0;
    end else if (I_CE && do_write && aw_addr_ff == `DTM_REG_CFG &&
                 w_strb_ff[0]) begin
      mode_ff       <= w_data_ff[`DTM_CFG_MODE_LSB +: 2];
      lvdc_ff       <= w_data_ff[`DTM_CFG_LVDC];
      supply_req_ff <= w_data_ff[`DTM_CFG_SUPPLY];
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (I_SYS_RST) begin
      O_ARREADY <= 1'b0;
      O_RVALID  <= 1'b0;
      O_RDATA   <= 32'h0000_0000;
      O_RRESP   <= 2'h0;
    end else if (I_CE) begin
      O_ARREADY <= !O_RVALID && !(I_ARVALID && O_ARREADY);
      if (I_ARVALID && O_ARREADY) begin
        O_RVALID <= 1'b1;
        O_RRESP  <= 2'h0;
        O_RDATA  <= 32'h0000_0000;
        unique case (I_ARADDR)
          `DTM_REG_CTRL: O_RDATA <= 32'h0000_0000;
          `DTM_REG_CFG:
            O_RDATA <= {28'h0, supply_req_ff, lvdc_ff, mode_ff};
          `DTM_REG_STATUS:
            O_RDATA <= {25'h0, O_SUPPLY_SEL, O_STOP_REQ, !hf_lock_ff,
                        I_BUS_BELOW_RESTART, tune_inh_ff, resettable,
                        active_ff};
          `DTM_REG_TRIP: O_RDATA <= {24'h0, code_ff};
          default: O_RRESP <= 2'h2;
        endcase
      end else if (O_RVALID && I_RREADY) begin
        O_RVALID <= 1'b0;
      end
    end
  end

endmodule

// *** sim/dtm_trip_props.sv ***
// assertions on the trip manager ports
module dtm_trip_props (
  // clock and reset
  input wire logic       I_SYS_CLK,
  input wire logic       I_SYS_RST,
  // drive side inputs
  input wire logic       I_FAULT_VALID,
  input wire logic       I_MOTOR_STOPPED,
  input wire logic       I_BUS_BELOW_RESTART,
  // drive side outputs
  input wire logic [7:0] O_TRIP_CODE,
  input wire logic       O_TRIP_ACTIVE,
  input wire logic       O_RUN_ENABLE,
  input wire logic       O_HEALTHY_RELAY,
  input wire logic       O_COMMS_ENABLE,
  input wire logic       O_STOP_REQ,
  input wire logic       O_SUPPLY_SEL
);
  default clocking cb @(posedge I_SYS_CLK);
  endclocking
  default disable iff (I_SYS_RST);
  logic uv;
  logic pri2;
  logic comms_seen_ff;
  // comms low is a lock only once it has been up since reset
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SYS_RST) comms_seen_ff <= 1'b0;
    else if (O_COMMS_ENABLE) comms_seen_ff <= 1'b1;
  end
  assign uv = O_TRIP_CODE == 8'h01;
  assign pri2 = O_TRIP_CODE inside {[8'hD9:8'hE8], 8'hC8, 8'hCD, 8'hD2};
  ////////////////////////////////////////////////////////////////////////////
  AST_CODE_RANGE:
    assert property (O_TRIP_ACTIVE && O_COMMS_ENABLE |->
      O_TRIP_CODE inside {[8'h01:8'hE8]})
    else $error("trip code out of range");
  AST_NONE_ZERO:
    assert property (!O_TRIP_ACTIVE |-> O_TRIP_CODE == 8'h00)
    else $error("code shown without trip");
  AST_HF_LATCH:
    assert property (comms_seen_ff && !O_COMMS_ENABLE |=>
      !O_COMMS_ENABLE && !O_HEALTHY_RELAY && !O_RUN_ENABLE)
    else $error("hardware fault released");
  AST_PRI2_HOLD:
    assert property (O_TRIP_ACTIVE && pri2 |=> O_TRIP_ACTIVE)
    else $error("power cycle trip cleared");
  AST_UV_NO_RUN:
    assert property (uv [*2] |-> !O_RUN_ENABLE)
    else $error("run enabled in undervoltage");
  AST_UV_HOLD:
    assert property (uv && I_BUS_BELOW_RESTART |=> O_TRIP_ACTIVE)
    else $error("undervoltage cleared while low");
  AST_UV_CLEAR:
    assert property ((uv && !I_BUS_BELOW_RESTART && !I_FAULT_VALID) [*2]
      |-> ##[0:2] !uv)
    else $error("undervoltage not self cleared");
  AST_OTHER_KEPT:
    assert property (O_TRIP_ACTIVE && !uv && $fell(I_BUS_BELOW_RESTART)
      |=> O_TRIP_ACTIVE [*2])
    else $error("other trip cleared by bus recovery");
  AST_STOP_FIRST:
    assert property ((O_STOP_REQ && !I_MOTOR_STOPPED && !O_TRIP_ACTIVE) [*3]
      |=> O_TRIP_CODE != 8'h20)
    else $error("phase loss tripped before stop");
  AST_SUPPLY_SWITCH:
    assert property ($changed(O_SUPPLY_SEL) |-> $past(I_BUS_BELOW_RESTART)
      || $past(I_BUS_BELOW_RESTART, 2) || $past(I_BUS_BELOW_RESTART, 3))
    else $error("supply switched outside undervoltage");
endmodule

bind dtm_trip_manager dtm_trip_props u_props (
  .I_SYS_CLK(I_SYS_CLK), .I_SYS_RST(I_SYS_RST),
  .I_FAULT_VALID(I_FAULT_VALID), .I_MOTOR_STOPPED(I_MOTOR_STOPPED),
  .I_BUS_BELOW_RESTART(I_BUS_BELOW_RESTART), .O_TRIP_CODE(O_TRIP_CODE),
  .O_TRIP_ACTIVE(O_TRIP_ACTIVE), .O_RUN_ENABLE(O_RUN_ENABLE),
  .O_HEALTHY_RELAY(O_HEALTHY_RELAY), .O_COMMS_ENABLE(O_COMMS_ENABLE),
  .O_STOP_REQ(O_STOP_REQ), .O_SUPPLY_SEL(O_SUPPLY_SEL)
);

// *** sim/dtm_code_reader.sv ***
// serial master model reading registers over the read channels
module dtm_code_reader (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // request side
  input  wire logic        i_start,
  input  wire logic [11:0] i_addr,
  input  wire logic [3:0]  i_delay,
  output logic             o_busy,
  output logic [31:0]      o_data,
  output logic [1:0]       o_resp,
  // read channels
  output logic             o_arvalid,
  input  wire logic        i_arready,
  output logic [11:0]      o_araddr,
  input  wire logic        i_rvalid,
  output logic             o_rready,
  input  wire logic [31:0] i_rdata,
  input  wire logic [1:0]  i_rresp
);
  logic [3:0] wait_ff;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_busy <= 1'b0;
      o_arvalid <= 1'b0;
      o_rready <= 1'b0;
      o_araddr <= 12'hFFF;
      o_data <= 32'h0;
      o_resp <= 2'h0;
      wait_ff <= 4'h0;
    end else if (i_start && !o_busy) begin
      o_busy <= 1'b1;
      wait_ff <= i_delay;
    end else if (o_busy) begin
      if (wait_ff != 4'h0) begin
        wait_ff <= wait_ff - 4'h1;
      end else if (!o_arvalid && !o_rready) begin
        o_arvalid <= 1'b1;
        o_rready <= 1'b1;
        o_araddr <= i_addr;
      end
      // released address shows its inverse
      if (o_arvalid && i_arready) begin
        o_arvalid <= 1'b0;
        o_araddr <= ~o_araddr;
      end
      if (o_rready && i_rvalid) begin
        o_rready <= 1'b0;
        o_data <= i_rdata;
        o_resp <= i_rresp;
        o_busy <= 1'b0;
      end
    end
  end
endmodule

// *** sim/drive_trip_manager_tb_top.sv ***
// self-checking testbench of the drive trip manager
module drive_trip_manager_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst, fv, pu, mstop, bus_lo, ureset, runq, awv, wv, bry, rd_go;
  logic awr, wrdy, bv, arv, arr, rv, rr, rd_busy;
  logic act, run_en, hlth, comms, stopq, save, sup, ce, dis;
  logic [7:0] fc, code;
  logic [11:0] awa, ara, rd_a;
  logic [31:0] wd, rdata, rd_d;
  logic [3:0] rd_dly;
  logic [1:0] br, rresp, rd_resp, wr_resp;
  int errors, n_compared, saves, s0, i;
  logic [7:0] c1, c2, ex;
  logic [7:0] first [7] = '{8'h02, 8'hBE, 8'hC4, 8'hA1, 8'hA7, 8'h03, 8'h59};
  logic [7:0] second [13] = '{8'h02, 8'h1F, 8'hD9, 8'hC8, 8'hCD, 8'hD2,
    8'hE8, 8'h09, 8'hBD, 8'hB1, 8'hBB, 8'h03, 8'h68};
  logic [7:0] stops [3] = '{8'h1E, 8'h20, 8'h1B};
  ////////////////////////////////////////////////////////////////////////////
  dtm_trip_manager dut (
    .I_SYS_CLK(clk), .I_SYS_RST(rst), .I_CE(ce), .I_FAULT_VALID(fv),
    .I_FAULT_CODE(fc), .I_POWERING_UP(pu), .I_MOTOR_STOPPED(mstop),
    .I_BUS_BELOW_RESTART(bus_lo), .I_USER_RESET(ureset),
    .I_DRIVE_DISABLED(dis), .I_RUN_REQ(runq), .I_AWVALID(awv),
    .O_AWREADY(awr), .I_AWADDR(awa), .I_WVALID(wv), .O_WREADY(wrdy),
    .I_WDATA(wd), .I_WSTRB(4'hF), .O_BVALID(bv), .I_BREADY(bry),
    .O_BRESP(br), .I_ARVALID(arv), .O_ARREADY(arr), .I_ARADDR(ara),
    .O_RVALID(rv), .I_RREADY(rr), .O_RDATA(rdata), .O_RRESP(rresp),
    .O_TRIP_CODE(code), .O_TRIP_ACTIVE(act), .O_RUN_ENABLE(run_en),
    .O_HEALTHY_RELAY(hlth), .O_COMMS_ENABLE(comms), .O_STOP_REQ(stopq),
    .O_SAVE_PARAMS(save), .O_SUPPLY_SEL(sup));
  dtm_code_reader u_reader (
    .i_clk(clk), .i_rst(rst), .i_start(rd_go), .i_addr(rd_a),
    .i_delay(rd_dly), .o_busy(rd_busy), .o_data(rd_d), .o_resp(rd_resp),
    .o_arvalid(arv), .i_arready(arr), .o_araddr(ara), .i_rvalid(rv),
    .o_rready(rr), .i_rdata(rdata), .i_rresp(rresp));
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) if (save === 1'b1) saves++;
  initial begin
    repeat (100000) @(posedge clk);
    errors++;
    complete_run();
  end
  ////////////////////////////////////////////////////////////////////////////
  function automatic int pri(logic [7:0] c, logic p);
    if (c == 8'hFF) return 1;
    if (c inside {[8'hD9:8'hE8], 8'hC8, 8'hCD, 8'hD2}) return 2;
    if (c == 8'h1F) return 3;
    if (c inside {8'hAF, [8'hB1:8'hBC]}) return p ? 5 : 4;
    if (c inside {8'h09, 8'hBD}) return 4;
    return (c == 8'h01) ? 6 : 5;
  endfunction
  // winner of a new trip against the active one
  function automatic logic [7:0] win(logic [7:0] o, logic [7:0] n, logic p);
    if (n inside {8'h09, 8'hBD} && pri(o, p) == 5)
      return (o inside {[8'hBE:8'hC4], [8'hA1:8'hA7]}) ? n : o;
    return (pri(n, p) < pri(o, p)) ? n : o;
  endfunction
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(logic [31:0] seen, logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic pwr(logic lo);
    @(posedge clk);
    rst <= 1'b1;
    bus_lo <= lo;
    pu <= 1'b0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic flt(logic [7:0] c);
    @(posedge clk);
    fv <= 1'b1;
    fc <= c;
    @(posedge clk);
    fv <= 1'b0;
    fc <= ~c;
    repeat (4) @(posedge clk);
  endtask
  task automatic urst();
    @(posedge clk);
    ureset <= 1'b1;
    @(posedge clk);
    ureset <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic wr(logic [11:0] a, logic [31:0] d);
    int k;
    @(posedge clk);
    awv <= 1'b1;
    wv <= 1'b1;
    awa <= a;
    wd <= d;
    bry <= 1'b1;
    for (k = 0; k < 60; k++) begin
      @(posedge clk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wrdy) wv <= 1'b0;
      if (bry && bv) begin
        bry <= 1'b0;
        wr_resp = br;
        break;
      end
    end
    if (k == 60) begin
      errors++;
      complete_run();
    end
  endtask
  task automatic rd(logic [11:0] a);
    int k;
    @(posedge clk);
    rd_a <= a;
    rd_dly <= 4'($urandom % 16);
    rd_go <= 1'b1;
    @(posedge clk);
    rd_go <= 1'b0;
    for (k = 0; k < 60; k++) begin
      @(posedge clk);
      if (!rd_busy) break;
    end
    if (k == 60) begin
      errors++;
      complete_run();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {rst, fv, pu, mstop, bus_lo, ureset, runq, awv, wv, bry, rd_go} = 11'h400;
    ce = 1'b1;
    dis = 1'b0;
    fc = 8'h00;
    awa = 12'h000;
    wd = 32'h0;
    rd_a = 12'h000;
    rd_dly = 4'h0;
    errors = 0;
    n_compared = 0;
    saves = 0;
    s0 = $urandom(32'h52F4);
    pwr(1'b0);
    chk(act, 1'b0);
    chk(code, 8'h00);
    rd(12'h010);
    chk(rd_resp, 2'b10);
    chk(rd_d, 32'h0);
    for (i = 0; i < 16; i++) begin
      pwr(1'b0);
      c1 = first[$urandom % 7];
      if ($urandom % 2) c1 = 8'(40 + $urandom % 50);
      c2 = second[$urandom % 13];
      pu <= 1'($urandom);
      runq <= 1'($urandom);
      dis <= 1'($urandom);
      flt(c1);
      chk(code, c1);
      ex = win(c1, c2, pu);
      flt(c2);
      chk(code, ex);
      urst();
      chk(code, ex);
      rd(12'h00C);
      chk(rd_d, 32'(ex));
      chk(rd_resp, 2'b00);
    end
    flt(8'hFF);
    chk(comms, 1'b0);
    chk(hlth, 1'b0);
    urst();
    chk(act, 1'b1);
    chk(comms, 1'b0);
    chk(run_en, 1'b0);
    pwr(1'b0);
    chk(act, 1'b0);
    flt(8'h1F);
    wr(12'h000, 32'h1);
    repeat (3) @(posedge clk);
    chk(code, 8'h1F);
    wr(12'h000, 32'h2);
    wr(12'h000, 32'h1);
    repeat (3) @(posedge clk);
    chk(act, 1'b0);
    wr(12'h020, 32'h1);
    chk(wr_resp, 2'b10);
    runq <= 1'b1;
    s0 = saves;
    pwr(1'b1);
    repeat (4) @(posedge clk);
    chk(code, 8'h01);
    chk(saves, s0);
    chk(run_en, 1'b0);
    urst();
    chk(code, 8'h01);
    wr(12'h004, 32'h8);
    chk(wr_resp, 2'b00);
    repeat (3) @(posedge clk);
    chk(sup, 1'b1);
    bus_lo <= 1'b0;
    repeat (6) @(posedge clk);
    chk(act, 1'b0);
    wr(12'h004, 32'h0);
    repeat (3) @(posedge clk);
    chk(sup, 1'b1);
    s0 = saves;
    bus_lo <= 1'b1;
    repeat (6) @(posedge clk);
    chk(code, 8'h01);
    chk(saves, s0 + 1);
    bus_lo <= 1'b0;
    repeat (6) @(posedge clk);
    wr(12'h004, 32'h4);
    bus_lo <= 1'b1;
    repeat (6) @(posedge clk);
    chk(saves, s0 + 1);
    flt(8'h02);
    chk(code, 8'h02);
    bus_lo <= 1'b0;
    repeat (6) @(posedge clk);
    chk(code, 8'h02);
    for (i = 0; i < 3; i++) begin
      pwr(1'b0);
      mstop <= 1'b0;
      wr(12'h004, 32'h1);
      flt(stops[i]);
      chk(stopq, 1'b1);
      chk(act, 1'b0);
      mstop <= 1'b1;
      repeat (4) @(posedge clk);
      chk(code, stops[i]);
    end
    pwr(1'b0);
    mstop <= 1'b0;
    chk(run_en, 1'b1);
    ce <= 1'b0;
    flt(8'h1E);
    chk(code, 8'h00);
    ce <= 1'b1;
    flt(8'h1E);
    chk(code, 8'h1E);
    complete_run();
  end
endmodule
